// *** src/lig_pkg.sv ***
package lig_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [7:0] LIG_IDX_REVISION = 8'h02;
  localparam logic [7:0] LIG_IDX_SOFT_RESET = 8'h04;
  localparam logic [7:0] LIG_IDX_OBSERVE = 8'h05;
  localparam logic [7:0] LIG_IDX_PIN_CTRL = 8'h06;
  localparam logic [7:0] LIG_IDX_REF_ROUTE = 8'h07;
  localparam logic [7:0] LIG_IDX_IRQ_CHANNELS = 8'h09;
  localparam logic [7:0] LIG_IDX_GLOBAL_CFG = 8'h20;
  localparam logic [7:0] LIG_IDX_NONE = 8'hFF;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int LIG_PIN_DIR_LSB = 0;
  localparam int LIG_PIN_LEVEL_LSB = 2;
  localparam int LIG_REF_A_LSB = 0;
  localparam int LIG_REF_B_LSB = 3;
  localparam int LIG_LINE_STD_BIT = 0;

  // ==========================================================
  // bus encodings
  // ==========================================================
  localparam logic [1:0] LIG_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] LIG_HSIZE_WORD = 3'h2;
  localparam logic LIG_HRESP_OKAY = 1'b0;

  // ==========================================================
  // values after reset
  // ==========================================================
  // arbitrary revision value, not tied to any real silicon
  localparam logic [7:0] LIG_REVISION_DEFAULT = 8'hA5;
  localparam logic [3:0] LIG_OBSERVE_RST = 4'h0;
  localparam logic [1:0] LIG_PIN_DIR_RST = 2'h3;
  localparam logic [1:0] LIG_PIN_LEVEL_RST = 2'h0;
  localparam logic [2:0] LIG_REF_SEL_RST = 3'h0;
  localparam logic [7:0] LIG_IRQ_RST = 8'h00;
  localparam logic LIG_LINE_STD_RST = 1'b0;

  typedef enum logic [1:0] {
    LIG_BUS_IDLE,
    LIG_BUS_FETCH,
    LIG_BUS_ANSWER
  } lig_bus_phase_t;

  typedef struct packed {
    lig_bus_phase_t phase;
    logic write;
    logic word;
    logic [7:0] idx;
    logic [31:0] rdata;
    logic [3:0] observe;
    logic [1:0] pin_dir;
    logic [1:0] pin_level;
    logic [2:0] ref_a_sel;
    logic [2:0] ref_b_sel;
    logic [7:0] irq;
    logic line_std;
    logic soft_pulse;
    logic drv_hiz;
  } lig_top_state_t;

  localparam lig_top_state_t LIG_TOP_RESET = '{
    phase: LIG_BUS_IDLE,
    write: 1'b0,
    word: 1'b0,
    idx: LIG_IDX_NONE,
    rdata: 32'h0000_0000,
    observe: LIG_OBSERVE_RST,
    pin_dir: LIG_PIN_DIR_RST,
    pin_level: LIG_PIN_LEVEL_RST,
    ref_a_sel: LIG_REF_SEL_RST,
    ref_b_sel: LIG_REF_SEL_RST,
    irq: LIG_IRQ_RST,
    line_std: LIG_LINE_STD_RST,
    soft_pulse: 1'b0,
    drv_hiz: 1'b1
  };

  typedef struct packed {
    logic ref_a;
    logic ref_b;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic obs_rx;
    logic obs_tx;
    logic [2:0] obs_ch;
  } lig_route_state_t;

  localparam lig_route_state_t LIG_ROUTE_RESET = '{
    ref_a: 1'b0,
    ref_b: 1'b0,
    pin_out: 2'h0,
    pin_oe: 2'h0,
    obs_rx: 1'b0,
    obs_tx: 1'b0,
    obs_ch: 3'h0
  };

endpackage

// *** src/lig_route_if.sv ***
`timescale 1ns/10ps
`default_nettype none

interface lig_route_if;
  logic [3:0] observe;
  logic [1:0] pin_dir;
  logic [1:0] pin_level;
  logic [1:0] pin_in;
  logic [2:0] ref_a_sel;
  logic [2:0] ref_b_sel;
  logic soft_reset;

  modport regs (
    output observe,
    output pin_dir,
    output pin_level,
    output ref_a_sel,
    output ref_b_sel,
    output soft_reset,
    input pin_in
  );

  modport route (
    input observe,
    input pin_dir,
    input pin_level,
    input ref_a_sel,
    input ref_b_sel,
    input soft_reset,
    output pin_in
  );
endinterface

`default_nettype wire

// *** src/lig_route.sv ***
`timescale 1ns/10ps
`default_nettype none

module lig_route (
  input wire logic clk,
  input wire logic rst,
  lig_route_if.route rif,
  input wire logic [7:0] rx_clk,
  input wire logic [1:0] aux_pin_i,
  output logic [1:0] aux_pin_o,
  output logic [1:0] aux_pin_oe,
  output logic ref_output_a,
  output logic ref_output_b,
  output logic observe_rx,
  output logic observe_tx,
  output logic [2:0] observe_channel
);
  import lig_pkg::*;

  lig_route_state_t st_q;
  lig_route_state_t st_d;

  // ==========================================================
  // routing and pin drive
  // ==========================================================
  always_comb begin
    st_d = st_q;
    st_d.ref_a = rx_clk[rif.ref_a_sel];
    st_d.ref_b = rx_clk[rif.ref_b_sel];
    st_d.pin_oe = ~rif.pin_dir;
    st_d.pin_out = rif.pin_level;
    // code n observes channel n+1; zero in the low bits is plain operation
    st_d.obs_ch = rif.observe[2:0];
    st_d.obs_rx = ~rif.observe[3] & (rif.observe[2:0] != 3'h0);
    st_d.obs_tx = rif.observe[3] & (rif.observe[2:0] != 3'h0);
  end

  always_ff @(posedge clk) begin
    if (rst || rif.soft_reset) begin
      st_q <= LIG_ROUTE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // per pin connections
  // ==========================================================
  for (genvar i = 0; i < 2; i++) begin : g_pin
    assign aux_pin_o[i] = st_q.pin_out[i];
    assign aux_pin_oe[i] = st_q.pin_oe[i];
    assign rif.pin_in[i] = aux_pin_i[i];
  end

  assign ref_output_a = st_q.ref_a;
  assign ref_output_b = st_q.ref_b;
  assign observe_rx = st_q.obs_rx;
  assign observe_tx = st_q.obs_tx;
  assign observe_channel = st_q.obs_ch;

endmodule

`default_nettype wire

// *** src/lig_top.sv ***
// How it works
// - Revision register reads a fixed code, read-only
// - Writing soft reset restores all defaults except the line standard bit
// - Soft reset register holds no written value
// - After soft reset line drivers go high-Z
// - Soft reset keeps the line standard bit
// - Four-bit observe select, reset zero
// - Low codes observe receivers 2 to 8
// - High codes observe transmitters 2 to 8
// - Direction bits 1:0, one means input
// - Output pins drive their level bit
// - Input pins read back the pin level
// - Bits 5:3 route clock to second output
// - Bits 2:0 route clock to first output
// - Channel interrupt flags, read-only, reset zero
`timescale 1ns/10ps
`default_nettype none

module lig_top #(
  parameter logic [7:0] REVISION_CODE = lig_pkg::LIG_REVISION_DEFAULT
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [7:0] CHANNEL_IRQ,
  input wire logic [7:0] RECOVERED_CLK,
  input wire logic TX_DRIVER_ENABLE,
  input wire logic AUX_PIN0_I,
  output logic AUX_PIN0_O,
  output logic AUX_PIN0_OE,
  input wire logic AUX_PIN1_I,
  output logic AUX_PIN1_O,
  output logic AUX_PIN1_OE,
  output logic REF_OUTPUT_A,
  output logic REF_OUTPUT_B,
  output logic [3:0] OBSERVE_SELECT,
  output logic OBSERVE_RX,
  output logic OBSERVE_TX,
  output logic [2:0] OBSERVE_CHANNEL,
  output logic LINE_STANDARD_SELECT,
  output logic SOFT_RESET_PULSE,
  output logic LINE_DRIVER_HIZ
);
  import lig_pkg::*;

  lig_top_state_t st_q;
  lig_top_state_t st_d;
  logic accept;
  logic [7:0] req_idx;
  logic [1:0] level_view;
  logic [7:0] rd_byte;
  logic wr_hit;
  logic soft_hit;
  logic [7:0] wbyte;

  lig_route_if rif();

  // ==========================================================
  // address phase decode
  // ==========================================================
  // only NONSEQ is taken; the bus carries single transfers only
  assign accept = HSEL && HREADY && (HTRANS == LIG_HTRANS_NONSEQ);

  // anything above the index window is folded onto an unmapped index
  assign req_idx = (HADDR[31:10] != 22'h0) ? LIG_IDX_NONE : HADDR[9:2];

  // ==========================================================
  // register read view
  // ==========================================================
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      level_view[i] = st_q.pin_dir[i] ? rif.pin_in[i] : st_q.pin_level[i];
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (st_q.idx)
      LIG_IDX_REVISION: begin
        rd_byte = REVISION_CODE;
      end
      LIG_IDX_OBSERVE: begin
        rd_byte[3:0] = st_q.observe;
      end
      LIG_IDX_PIN_CTRL: begin
        rd_byte[LIG_PIN_DIR_LSB +: 2] = st_q.pin_dir;
        rd_byte[LIG_PIN_LEVEL_LSB +: 2] = level_view;
      end
      LIG_IDX_REF_ROUTE: begin
        rd_byte[LIG_REF_A_LSB +: 3] = st_q.ref_a_sel;
        rd_byte[LIG_REF_B_LSB +: 3] = st_q.ref_b_sel;
      end
      LIG_IDX_IRQ_CHANNELS: begin
        rd_byte = st_q.irq;
      end
      LIG_IDX_GLOBAL_CFG: begin
        rd_byte[LIG_LINE_STD_BIT] = st_q.line_std;
      end
      default: begin
        // soft reset register and unmapped space read as zero
        rd_byte = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // data phase write qualification
  // ==========================================================
  // narrow writes are dropped whole rather than half-applied
  assign wr_hit = (st_q.phase == LIG_BUS_FETCH) && st_q.write && st_q.word;
  assign soft_hit = wr_hit && (st_q.idx == LIG_IDX_SOFT_RESET);
  assign wbyte = HWDATA[7:0];

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    st_d = st_q;
    st_d.soft_pulse = 1'b0;
    st_d.irq = CHANNEL_IRQ;
    if (TX_DRIVER_ENABLE) begin
      st_d.drv_hiz = 1'b0;
    end
    case (st_q.phase)
      LIG_BUS_IDLE: begin
        if (accept) begin
          st_d.phase = LIG_BUS_FETCH;
          st_d.write = HWRITE;
          st_d.word = (HSIZE == LIG_HSIZE_WORD);
          st_d.idx = req_idx;
        end
      end
      LIG_BUS_FETCH: begin
        st_d.phase = LIG_BUS_ANSWER;
        if (!st_q.write) begin
          st_d.rdata = {24'h00_0000, rd_byte};
        end
        if (wr_hit) begin
          case (st_q.idx)
            LIG_IDX_OBSERVE: begin
              st_d.observe = wbyte[3:0];
            end
            LIG_IDX_PIN_CTRL: begin
              st_d.pin_dir = wbyte[LIG_PIN_DIR_LSB +: 2];
              st_d.pin_level = wbyte[LIG_PIN_LEVEL_LSB +: 2];
            end
            LIG_IDX_REF_ROUTE: begin
              st_d.ref_a_sel = wbyte[LIG_REF_A_LSB +: 3];
              st_d.ref_b_sel = wbyte[LIG_REF_B_LSB +: 3];
            end
            LIG_IDX_GLOBAL_CFG: begin
              st_d.line_std = wbyte[LIG_LINE_STD_BIT];
            end
            default: begin
              // revision, flags, soft reset and holes keep their value
              st_d.idx = st_q.idx;
            end
          endcase
        end
      end
      LIG_BUS_ANSWER: begin
        if (accept) begin
          st_d.phase = LIG_BUS_FETCH;
          st_d.write = HWRITE;
          st_d.word = (HSIZE == LIG_HSIZE_WORD);
          st_d.idx = req_idx;
        end else begin
          st_d.phase = LIG_BUS_IDLE;
        end
      end
      default: begin
        st_d.phase = LIG_BUS_IDLE;
      end
    endcase
    // soft reset overrides any write in the same cycle, but the bus
    // handshake and captured read data ride through untouched
    if (soft_hit) begin
      st_d.observe = LIG_TOP_RESET.observe;
      st_d.pin_dir = LIG_TOP_RESET.pin_dir;
      st_d.pin_level = LIG_TOP_RESET.pin_level;
      st_d.ref_a_sel = LIG_TOP_RESET.ref_a_sel;
      st_d.ref_b_sel = LIG_TOP_RESET.ref_b_sel;
      st_d.irq = LIG_TOP_RESET.irq;
      st_d.line_std = st_q.line_std;
      st_d.soft_pulse = 1'b1;
      st_d.drv_hiz = 1'b1;
    end
  end

  // ==========================================================
  // state register
  // ==========================================================
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      st_q <= LIG_TOP_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // bus answer
  // ==========================================================
  // one wait state on every transfer keeps read data registered
  assign HREADYOUT = (st_q.phase != LIG_BUS_FETCH);
  assign HRESP = LIG_HRESP_OKAY;
  assign HRDATA = st_q.rdata;

  // ==========================================================
  // routing block
  // ==========================================================
  assign rif.observe = st_q.observe;
  assign rif.pin_dir = st_q.pin_dir;
  assign rif.pin_level = st_q.pin_level;
  assign rif.ref_a_sel = st_q.ref_a_sel;
  assign rif.ref_b_sel = st_q.ref_b_sel;
  assign rif.soft_reset = st_q.soft_pulse;

  lig_route u_route (
    .clk(CLOCK),
    .rst(SYS_RST),
    .rif(rif.route),
    .rx_clk(RECOVERED_CLK),
    .aux_pin_i({AUX_PIN1_I, AUX_PIN0_I}),
    .aux_pin_o({AUX_PIN1_O, AUX_PIN0_O}),
    .aux_pin_oe({AUX_PIN1_OE, AUX_PIN0_OE}),
    .ref_output_a(REF_OUTPUT_A),
    .ref_output_b(REF_OUTPUT_B),
    .observe_rx(OBSERVE_RX),
    .observe_tx(OBSERVE_TX),
    .observe_channel(OBSERVE_CHANNEL)
  );

  // ==========================================================
  // status outputs
  // ==========================================================
  assign OBSERVE_SELECT = st_q.observe;
  assign LINE_STANDARD_SELECT = st_q.line_std;
  assign SOFT_RESET_PULSE = st_q.soft_pulse;
  assign LINE_DRIVER_HIZ = st_q.drv_hiz;

endmodule

`default_nettype wire

// *** verification/lig_chk.sv ***
`timescale 1ns/10ps
`default_nettype none

module lig_chk
  import lig_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [31:0] HRDATA,
  input wire logic AUX_PIN0_OE,
  input wire logic AUX_PIN1_OE,
  input wire logic [3:0] OBSERVE_SELECT,
  input wire logic OBSERVE_RX,
  input wire logic OBSERVE_TX,
  input wire logic [2:0] OBSERVE_CHANNEL,
  input wire logic LINE_STANDARD_SELECT,
  input wire logic SOFT_RESET_PULSE,
  input wire logic LINE_DRIVER_HIZ
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  // ==========================================================
  // bus side
  // ==========================================================
  chk_one_wait: assert property (HSEL && HREADY && HTRANS == LIG_HTRANS_NONSEQ
    |=> !HREADYOUT ##1 HREADYOUT) else $error("wait state not exactly one cycle");
  chk_resp_okay: assert property (HRESP == LIG_HRESP_OKAY) else $error("error response");
  chk_upper_zero: assert property (HRDATA[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  // ==========================================================
  // soft reset
  // ==========================================================
  chk_soft_defaults: assert property (SOFT_RESET_PULSE |->
    OBSERVE_SELECT == LIG_OBSERVE_RST && LINE_DRIVER_HIZ) else $error("soft reset defaults");
  chk_pulse_single: assert property (SOFT_RESET_PULSE |=> !SOFT_RESET_PULSE)
    else $error("soft reset pulse too long");
  chk_std_kept: assert property (SOFT_RESET_PULSE |-> $stable(LINE_STANDARD_SELECT))
    else $error("line standard lost on soft reset");
  chk_pins_release: assert property (SOFT_RESET_PULSE |=> !AUX_PIN0_OE && !AUX_PIN1_OE)
    else $error("aux pins still driven after soft reset");

  // ==========================================================
  // observe decode, one cycle behind the select
  // ==========================================================
  chk_rx_decode: assert property (OBSERVE_RX ==
    $past(!OBSERVE_SELECT[3] && OBSERVE_SELECT[2:0] != 3'h0)) else $error("rx observe");
  chk_tx_decode: assert property (OBSERVE_TX ==
    $past(OBSERVE_SELECT[3] && OBSERVE_SELECT[2:0] != 3'h0)) else $error("tx observe");
  chk_channel_follow: assert property (OBSERVE_CHANNEL == $past(OBSERVE_SELECT[2:0]))
    else $error("observed channel");

  cov_soft: cover property (SOFT_RESET_PULSE);
  cov_tx: cover property (OBSERVE_TX);
  cov_pin_out: cover property (AUX_PIN0_OE && !AUX_PIN1_OE);
endmodule

bind lig_top lig_chk u_chk (.*);

`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import lig_pkg::*;
  // arbitrary revision value
  localparam logic [7:0] REV = 8'h3C;
  logic CLOCK = 1'b0, SYS_RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, TX_DRIVER_ENABLE = 1'b0;
  logic [1:0] HTRANS = 2'h0, pin_drv = 2'h2;
  logic [2:0] HSIZE = LIG_HSIZE_WORD;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
  logic [7:0] CHANNEL_IRQ = 8'h00, RECOVERED_CLK = 8'h00;
  logic HREADYOUT, HRESP, AUX_PIN0_O, AUX_PIN0_OE, AUX_PIN1_O, AUX_PIN1_OE;
  logic REF_OUTPUT_A, REF_OUTPUT_B, OBSERVE_RX, OBSERVE_TX;
  logic LINE_STANDARD_SELECT, SOFT_RESET_PULSE, LINE_DRIVER_HIZ;
  logic [3:0] OBSERVE_SELECT;
  logic [2:0] OBSERVE_CHANNEL;
  // the wire follows whoever drives it
  wire pin0 = AUX_PIN0_OE ? AUX_PIN0_O : pin_drv[0];
  wire pin1 = AUX_PIN1_OE ? AUX_PIN1_O : pin_drv[1];
  int miscompares = 0, cmp_count = 0, cycles = 0, pulses = 0;

  lig_top #(.REVISION_CODE(REV)) uut (.*, .HREADY(HREADYOUT), .AUX_PIN0_I(pin0),
    .AUX_PIN1_I(pin1));

  always #20 CLOCK = ~CLOCK;

  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (SOFT_RESET_PULSE === 1'b1) pulses <= pulses + 1;
    if (cycles == 4000) begin
      miscompares = miscompares + 1;
      results();
    end
  end

  // ==========================================================
  // helpers
  // ==========================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ready sampled just before the edge, so no race with the design's update
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    logic ok;
    HSEL <= 1'b1;
    HTRANS <= LIG_HTRANS_NONSEQ;
    HWRITE <= w;
    HADDR <= {22'h0, idx, 2'h0};
    do begin
      @(negedge CLOCK);
      ok = HREADYOUT;
      @(posedge CLOCK);
    end while (ok !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, d};
    do begin
      @(negedge CLOCK);
      ok = HREADYOUT;
      rd = HRDATA;
      @(posedge CLOCK);
    end while (ok !== 1'b1);
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge CLOCK);
    @(negedge CLOCK);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  // ==========================================================
  initial begin
    repeat (16) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    bus(0, LIG_IDX_REVISION, 8'h00);
    chk(rd, 32'(REV));
    bus(0, LIG_IDX_OBSERVE, 8'h00);
    chk(rd, 32'h0);
    bus(0, LIG_IDX_PIN_CTRL, 8'h00);
    chk(rd, 32'h0B);
    bus(0, LIG_IDX_REF_ROUTE, 8'h00);
    chk(rd, 32'h0);
    bus(0, LIG_IDX_IRQ_CHANNELS, 8'h00);
    chk(rd, 32'h0);
    pause(0);
    chk(32'(LINE_DRIVER_HIZ), 32'h1);
    @(posedge CLOCK);
    $display("test reset values done");

    bus(1, LIG_IDX_REVISION, 8'hFF);
    bus(0, LIG_IDX_REVISION, 8'h00);
    chk(rd, 32'(REV));
    bus(1, 8'h0F, 8'hFF);
    bus(0, 8'h0F, 8'h00);
    chk(rd, 32'h0);
    $display("test read only done");

    for (int c = 0; c < 16; c++) begin
      bus(1, LIG_IDX_OBSERVE, 8'(c) | 8'hF0);
      bus(0, LIG_IDX_OBSERVE, 8'h00);
      chk(rd, 32'(c));
      pause(0);
      chk(32'({OBSERVE_SELECT, OBSERVE_TX, OBSERVE_RX, OBSERVE_CHANNEL}), 32'({4'(c),
        c[3] && c[2:0] != 0, !c[3] && c[2:0] != 0, 3'(c)}));
      @(posedge CLOCK);
    end
    $display("test observe done");

    bus(1, LIG_IDX_PIN_CTRL, 8'hFC);
    bus(0, LIG_IDX_PIN_CTRL, 8'h00);
    chk(rd, 32'h0C);
    pause(1);
    chk(32'({AUX_PIN1_OE, AUX_PIN1_O, AUX_PIN0_OE, AUX_PIN0_O}), 32'hF);
    @(posedge CLOCK);
    bus(1, LIG_IDX_PIN_CTRL, 8'h06);
    bus(0, LIG_IDX_PIN_CTRL, 8'h00);
    chk(rd, 32'h0E);
    pin_drv <= 2'h0;
    bus(0, LIG_IDX_PIN_CTRL, 8'h00);
    chk(rd, 32'h06);
    pause(0);
    chk(32'({AUX_PIN1_OE, AUX_PIN0_OE, AUX_PIN0_O}), 32'h3);
    @(posedge CLOCK);
    $display("test aux pins done");

    for (int s = 0; s < 8; s++) begin
      bus(1, LIG_IDX_REF_ROUTE, 8'((7 - s) << 3 | s) | 8'hC0);
      bus(0, LIG_IDX_REF_ROUTE, 8'h00);
      chk(rd, 32'((7 - s) << 3 | s));
      RECOVERED_CLK <= 8'h01 << s;
      pause(3);
      chk(32'({REF_OUTPUT_B, REF_OUTPUT_A}), 32'h1);
      @(posedge CLOCK);
      RECOVERED_CLK <= 8'h80 >> s;
      pause(3);
      chk(32'({REF_OUTPUT_B, REF_OUTPUT_A}), 32'h2);
      @(posedge CLOCK);
    end
    $display("test reference routing done");

    CHANNEL_IRQ <= 8'h5A;
    bus(1, LIG_IDX_IRQ_CHANNELS, 8'hFF);
    bus(0, LIG_IDX_IRQ_CHANNELS, 8'h00);
    chk(rd, 32'h5A);
    $display("test channel flags done");

    bus(1, LIG_IDX_GLOBAL_CFG, 8'h01);
    TX_DRIVER_ENABLE <= 1'b1;
    pause(2);
    chk(32'({LINE_STANDARD_SELECT, LINE_DRIVER_HIZ}), 32'h2);
    @(posedge CLOCK);
    TX_DRIVER_ENABLE <= 1'b0;
    pin_drv <= 2'h1;
    bus(1, LIG_IDX_SOFT_RESET, 8'h5A);
    pause(2);
    chk(32'(pulses), 32'h1);
    chk(32'({LINE_STANDARD_SELECT, LINE_DRIVER_HIZ}), 32'h3);
    chk(32'({AUX_PIN1_OE, AUX_PIN0_OE, OBSERVE_TX}), 32'h0);
    @(posedge CLOCK);
    bus(0, LIG_IDX_OBSERVE, 8'h00);
    chk(rd, 32'h0);
    bus(0, LIG_IDX_PIN_CTRL, 8'h00);
    chk(rd, 32'h07);
    bus(0, LIG_IDX_REF_ROUTE, 8'h00);
    chk(rd, 32'h0);
    bus(0, LIG_IDX_SOFT_RESET, 8'h00);
    chk(rd, 32'h0);
    $display("test soft reset done");
    results();
  end
endmodule

`default_nettype wire
